// file: pkg/sys_instr_regs.vh
// Constants for the barrier / trap / control-write execute block.
// Assumes a 32-bit R-type instruction word; included by bare name.
`ifndef SYS_INSTR_REGS_VH
`define SYS_INSTR_REGS_VH
`define OPC_LSB        0
`define OPC_W          6
`define OPX_LSB        11
`define OPX_W          6
`define FLD_A_LSB      27
`define FLD_B_LSB      22
`define FLD_C_LSB      17
`define FLD_W          5
`define FLD_N_LSB      6
`define TRAP_CODE_LSB  6
`define OPC_RTYPE      6'h3a
`define OPX_BARRIER    6'h36
`define OPX_TRAP       6'h2d
`define OPX_CTLWR      6'h2e
`define ST_INT_EN_BIT  0
`define ST_U_BIT       1
`define WORD_STEP      32'h0000_0004
`define STATUS_RST     32'h0000_0000
`define ADDR_RST       32'h0000_0000
`define DATA_RST       32'h0000_0000
`define IDX_RST        5'h00
`define EXC_HANDLER_DFLT 32'h0000_0020
`endif

// file: rtl/sys_instr_decode.v
// Decoder for the three R-type system instructions.
// Assumes a valid 32-bit instruction word; purely combinational.
`timescale 1ns/1ps
`include "sys_instr_regs.vh"
module sys_instr_decode
(
	// Instruction
	input  wire [31:0] i_instr,
	// Decoded kind and fields
	output wire        o_is_barrier,
	output wire        o_is_trap,
	output wire        o_is_ctlwr,
	output wire [4:0]  o_field_a,
	output wire [4:0]  o_field_n
);
	wire [5:0] opc;
	wire [5:0] opx;
	wire       rtype;
	assign opc = i_instr[`OPC_LSB +: `OPC_W];
	assign opx = i_instr[`OPX_LSB +: `OPX_W];
	assign rtype = (opc == `OPC_RTYPE);
	// Trap code bits are not looked at, so trap and trap 0 decode alike
	assign o_is_barrier = rtype && (opx == `OPX_BARRIER);
	assign o_is_trap    = rtype && (opx == `OPX_TRAP);
	assign o_is_ctlwr   = rtype && (opx == `OPX_CTLWR);
	assign o_field_a = i_instr[`FLD_A_LSB +: `FLD_W];
	assign o_field_n = i_instr[`FLD_N_LSB +: `FLD_W];
endmodule // sys_instr_decode

// file: rtl/barrier_trap_ctlwrite_exec.v
// Execute stage for memory barrier, software trap and control write.
// Assumes the pipeline holds i_valid/i_instr until o_ready; one clock.
//
// Contract
// - Barrier stalls later instructions until all issued memory accesses complete.
// - With in-order-only memory, barrier acts as a no-operation.
// - Trap copies status into saved status before changing status bits.
// - Trap writes trap address plus 4 into exception return address register.
// - Trap clears interrupt enable and user mode bits to zero.
// - Trap loads program counter with configured exception handler address.
// - Trap code field is ignored during execution.
// - Trap without argument behaves exactly as trap code zero.
// - Control write stores full source operand A into indexed control register; in user mode the code raises o_supervisor_exc and writes nothing.
// - Control register index comes from the N field of the instruction.
`timescale 1ns/1ps
`include "sys_instr_regs.vh"
module barrier_trap_ctlwrite_exec
#(
	parameter [31:0] EXC_HANDLER_ADDR = `EXC_HANDLER_DFLT,
	parameter        IN_ORDER_ONLY    = 0
)
(
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_srst,
	// Instruction in
	input  wire        i_valid,
	input  wire [31:0] i_instr,
	input  wire [31:0] i_instr_addr,
	input  wire [31:0] i_source_operand_a,
	// Core state
	input  wire [31:0] i_status,
	input  wire        i_mem_pending,
	// Pipeline handshake and register read index
	output wire        o_ready,
	output wire [4:0]  o_rf_read_idx,
	// Trap results
	output wire        o_trap_take,
	output wire [31:0] o_estatus,
	output wire [31:0] o_status_new,
	output wire [31:0] o_exception_return_addr_reg,
	output wire [31:0] o_program_counter,
	// Control write results
	output wire        o_ctl_we,
	output wire [4:0]  o_indexed_control_reg,
	output wire [31:0] o_ctl_wdata,
	output wire        o_supervisor_exc
);
	// Drain tracker: run normally, or wait for memory to settle
	localparam ST_RUN   = 1'h0;
	localparam ST_DRAIN = 1'h1;

	// Address of the next word; carry out dropped on purpose
	function [31:0] next_word_addr;
		input [31:0] addr;
		reg   [32:0] sum;
		begin
			sum            = {1'h0, addr} + {1'h0, `WORD_STEP};
			next_word_addr = sum[31:0];
		end
	endfunction

	// Status with interrupt enable and user mode forced low
	function [31:0] trap_status;
		input [31:0] status;
		reg   [31:0] mask;
		begin
			mask        = (32'h0000_0001 << `ST_INT_EN_BIT) | (32'h0000_0001 << `ST_U_BIT);
			trap_status = status & ~mask;
		end
	endfunction

	// Decoder results
	wire        is_barrier;
	wire        is_trap;
	wire        is_ctlwr;
	wire [4:0]  field_a;
	wire [4:0]  field_n;
	// Qualified requests
	wire        user_mode;
	wire        do_barrier;
	wire        do_trap;
	wire        do_ctlwr;
	wire        stall;
	// Registers and their next values
	reg         state_q;
	reg         state_d;
	reg         ready_q;
	reg         ready_d;
	reg  [4:0]  rf_read_idx_q;
	reg  [4:0]  rf_read_idx_d;
	reg         trap_take_q;
	reg         trap_take_d;
	reg  [31:0] estatus_q;
	reg  [31:0] estatus_d;
	reg  [31:0] status_new_q;
	reg  [31:0] status_new_d;
	reg  [31:0] return_addr_q;
	reg  [31:0] return_addr_d;
	reg  [31:0] program_counter_q;
	reg  [31:0] program_counter_d;
	reg         ctl_we_q;
	reg         ctl_we_d;
	reg  [4:0]  ctl_index_q;
	reg  [4:0]  ctl_index_d;
	reg  [31:0] ctl_wdata_q;
	reg  [31:0] ctl_wdata_d;
	reg         supervisor_exc_q;
	reg         supervisor_exc_d;

	sys_instr_decode u_dec
	(
		.i_instr      (i_instr),
		.o_is_barrier (is_barrier),
		.o_is_trap    (is_trap),
		.o_is_ctlwr   (is_ctlwr),
		.o_field_a    (field_a),
		.o_field_n    (field_n)
	);

	assign user_mode  = i_status[`ST_U_BIT];
	assign do_barrier = i_valid && is_barrier;
	assign do_trap    = i_valid && is_trap;
	assign do_ctlwr   = i_valid && is_ctlwr;
	// In-order memory cannot reorder, so the barrier never waits there
	assign stall = do_barrier && (IN_ORDER_ONLY == 0) && i_mem_pending;

	// Ready is low for every cycle spent draining; it lags pending by one
	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_RUN:
			begin
				if (stall)
					state_d = ST_DRAIN;
			end
			ST_DRAIN:
			begin
				if (!stall)
					state_d = ST_RUN;
			end
			default:
			begin
				state_d = ST_RUN;
			end
		endcase
		ready_d = (state_d == ST_RUN);
	end

	// Source register index, read ahead for the caller
	always @*
	begin
		rf_read_idx_d = field_a;
	end

	// Trap results; data holds until the next trap
	always @*
	begin
		trap_take_d       = 1'h0;
		estatus_d         = estatus_q;
		status_new_d      = status_new_q;
		return_addr_d     = return_addr_q;
		program_counter_d = program_counter_q;
		if (do_trap)
		begin
			trap_take_d       = 1'h1;
			estatus_d         = i_status;
			status_new_d      = trap_status(i_status);
			return_addr_d     = next_word_addr(i_instr_addr);
			program_counter_d = EXC_HANDLER_ADDR;
		end
	end

	// Control write; user mode gets the exception and no write
	always @*
	begin
		ctl_we_d         = 1'h0;
		ctl_index_d      = ctl_index_q;
		ctl_wdata_d      = ctl_wdata_q;
		supervisor_exc_d = 1'h0;
		if (do_ctlwr)
		begin
			if (user_mode)
			begin
				supervisor_exc_d = 1'h1;
			end
			else
			begin
				ctl_we_d    = 1'h1;
				ctl_index_d = field_n;
				ctl_wdata_d = i_source_operand_a;
			end
		end
	end

	always @(posedge i_clk)
	begin
		if (i_srst)
		begin
			state_q           <= ST_RUN;
			ready_q           <= 1'h0;
			rf_read_idx_q     <= `IDX_RST;
			trap_take_q       <= 1'h0;
			estatus_q         <= `STATUS_RST;
			status_new_q      <= `STATUS_RST;
			return_addr_q     <= `ADDR_RST;
			program_counter_q <= `ADDR_RST;
			ctl_we_q          <= 1'h0;
			ctl_index_q       <= `IDX_RST;
			ctl_wdata_q       <= `DATA_RST;
			supervisor_exc_q  <= 1'h0;
		end
		else
		begin
			state_q           <= state_d;
			ready_q           <= ready_d;
			rf_read_idx_q     <= rf_read_idx_d;
			trap_take_q       <= trap_take_d;
			estatus_q         <= estatus_d;
			status_new_q      <= status_new_d;
			return_addr_q     <= return_addr_d;
			program_counter_q <= program_counter_d;
			ctl_we_q          <= ctl_we_d;
			ctl_index_q       <= ctl_index_d;
			ctl_wdata_q       <= ctl_wdata_d;
			supervisor_exc_q  <= supervisor_exc_d;
		end
	end

	// Every output comes straight from its flip-flop
	assign o_ready                     = ready_q;
	assign o_rf_read_idx               = rf_read_idx_q;
	assign o_trap_take                 = trap_take_q;
	assign o_estatus                   = estatus_q;
	assign o_status_new                = status_new_q;
	assign o_exception_return_addr_reg = return_addr_q;
	assign o_program_counter           = program_counter_q;
	assign o_ctl_we                    = ctl_we_q;
	assign o_indexed_control_reg       = ctl_index_q;
	assign o_ctl_wdata                 = ctl_wdata_q;
	assign o_supervisor_exc            = supervisor_exc_q;
endmodule // barrier_trap_ctlwrite_exec

// file: test/sys_exec_checker.sv
// Assertions for the system instruction execute block.
// Bound to its top; one clock, sync reset.
`timescale 1ns/1ps
module sys_exec_checker
#(
	parameter [31:0] EXC_HANDLER_ADDR = 32'h0000_0020,
	parameter        IN_ORDER_ONLY    = 0
)
(
	input wire logic i_clk, i_srst, i_valid, i_mem_pending, o_ready, o_trap_take, o_ctl_we, o_supervisor_exc,
	input wire logic [31:0] i_instr, i_instr_addr, i_source_operand_a, i_status, o_estatus, o_status_new,
	input wire logic [31:0] o_exception_return_addr_reg, o_program_counter, o_ctl_wdata,
	input wire logic [4:0] o_indexed_control_reg, o_rf_read_idx
);
	wire r = i_valid && i_instr[5:0] == 6'h3a;
	wire t = r && i_instr[16:11] == 6'h2d;
	wire c = r && i_instr[16:11] == 6'h2e;
	wire b = r && i_instr[16:11] == 6'h36;
	wire [4:0] n = i_instr[10:6];
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	chk_trap_jump: assert property (t |=> o_trap_take && o_program_counter == EXC_HANDLER_ADDR)
		else $error("jump");
	chk_trap_return: assert property (t |=> o_exception_return_addr_reg == $past(i_instr_addr) + 32'h0000_0004)
		else $error("return");
	chk_trap_save: assert property (t |=> o_estatus == $past(i_status))
		else $error("save");
	chk_trap_clear: assert property (t |=> o_status_new == ($past(i_status) & 32'hffff_fffc))
		else $error("clr");
	chk_ctl_write: assert property (c && !i_status[1] |=> o_ctl_we && o_ctl_wdata == $past(i_source_operand_a))
		else $error("wr");
	chk_ctl_index: assert property (c && !i_status[1] |=> o_indexed_control_reg == $past(n))
		else $error("idx");
	chk_user_refuse: assert property (c && i_status[1] |=> !o_ctl_we && o_supervisor_exc && $stable(o_ctl_wdata))
		else $error("user");
	chk_barrier_hold: assert property (IN_ORDER_ONLY == 0 && b && i_mem_pending |=> !o_ready)
		else $error("bar");
	chk_barrier_free: assert property (!(b && i_mem_pending) |=> o_ready)
		else $error("free");
	chk_barrier_noop: assert property (IN_ORDER_ONLY != 0 && b |=> o_ready)
		else $error("noop");
	chk_read_index: assert property (1'b1 |=> o_rf_read_idx == $past(i_instr[31:27]))
		else $error("ridx");
	chk_other_quiet: assert property (!t && !c |=> !o_trap_take && !o_ctl_we && !o_supervisor_exc)
		else $error("odd");
	cov_trap: cover property (t);
	cov_ctl_write: cover property (c && !i_status[1]);
	cov_user_refuse: cover property (c && i_status[1]);
	cov_stall: cover property (!o_ready);
endmodule // sys_exec_checker
bind barrier_trap_ctlwrite_exec sys_exec_checker
#(
	.EXC_HANDLER_ADDR (EXC_HANDLER_ADDR),
	.IN_ORDER_ONLY    (IN_ORDER_ONLY)
)
u_chk
(
	.i_clk (i_clk), .i_srst (i_srst), .i_valid (i_valid), .i_mem_pending (i_mem_pending),
	.o_ready (o_ready), .o_trap_take (o_trap_take), .o_ctl_we (o_ctl_we), .o_supervisor_exc (o_supervisor_exc),
	.i_instr (i_instr), .i_instr_addr (i_instr_addr), .i_source_operand_a (i_source_operand_a),
	.i_status (i_status), .o_estatus (o_estatus), .o_status_new (o_status_new),
	.o_exception_return_addr_reg (o_exception_return_addr_reg), .o_program_counter (o_program_counter),
	.o_ctl_wdata (o_ctl_wdata), .o_indexed_control_reg (o_indexed_control_reg), .o_rf_read_idx (o_rf_read_idx)
);

// file: test/barrier_trap_ctlwrite_exec_test.sv
// Random bench for the system instruction execute block.
// Drives at rising edges, checks at falling edges.
`timescale 1ns/1ps
module barrier_trap_ctlwrite_exec_test;
	logic i_clk = 0, i_srst = 1, i_valid = 0, i_mem_pending = 0, h, d, rs, io_ready;
	logic [31:0] i_instr = 0, i_instr_addr = 0, i_source_operand_a = 0, i_status = 0, p, q, w, a, s, ew = 0;
	logic o_ready, o_trap_take, o_ctl_we, o_supervisor_exc;
	logic [31:0] o_estatus, o_status_new, o_exception_return_addr_reg, o_program_counter, o_ctl_wdata;
	logic [4:0] o_rf_read_idx, o_indexed_control_reg, ei = 0;
	logic [5:0] x;
	integer seed = 24078, num_errors = 0, comparisons = 0, k;
	always #12.5 i_clk = ~i_clk;
	barrier_trap_ctlwrite_exec u_barrier_trap_ctlwrite_exec
	(
		.i_clk (i_clk), .i_srst (i_srst), .i_valid (i_valid), .i_instr (i_instr), .i_instr_addr (i_instr_addr),
		.i_source_operand_a (i_source_operand_a), .i_status (i_status), .i_mem_pending (i_mem_pending),
		.o_ready (o_ready), .o_rf_read_idx (o_rf_read_idx), .o_trap_take (o_trap_take), .o_estatus (o_estatus),
		.o_status_new (o_status_new), .o_exception_return_addr_reg (o_exception_return_addr_reg),
		.o_program_counter (o_program_counter), .o_ctl_we (o_ctl_we), .o_indexed_control_reg (o_indexed_control_reg),
		.o_ctl_wdata (o_ctl_wdata), .o_supervisor_exc (o_supervisor_exc)
	);
	// Same block built for in-order memory, where the barrier never waits
	barrier_trap_ctlwrite_exec #(.IN_ORDER_ONLY(1)) u_barrier_trap_ctlwrite_exec_in_order
	(
		.i_clk (i_clk), .i_srst (i_srst), .i_valid (i_valid), .i_instr (i_instr), .i_instr_addr (i_instr_addr),
		.i_source_operand_a (i_source_operand_a), .i_status (i_status), .i_mem_pending (i_mem_pending),
		.o_ready (io_ready), .o_rf_read_idx (), .o_trap_take (), .o_estatus (), .o_status_new (),
		.o_exception_return_addr_reg (), .o_program_counter (), .o_ctl_we (), .o_indexed_control_reg (),
		.o_ctl_wdata (), .o_supervisor_exc ()
	);
	function logic hit(input [5:0] v);
		return !rs && h && p[5:0] == 6'h3a && p[16:11] == v;
	endfunction
	function logic [31:0] cleared(input [31:0] v);
		return v & 32'hffff_fffc;
	endfunction
	task ck(input [31:0] g, e);
		comparisons++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected %0t got %h want %h", $time, g, e);
		end
	endtask
	task conclude;
		$display("%0d compared, %0d wrong", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge i_clk);
		i_srst <= 0;
		@(negedge i_clk);
		ck({o_ready, o_trap_take, o_ctl_we, o_supervisor_exc, io_ready}, 5'h00);
		ck(o_program_counter | o_exception_return_addr_reg | o_estatus | o_status_new, 32'h0000_0000);
		$display("reset test done");
		for (k = 0; k < 900; k++)
		begin
			@(posedge i_clk);
			{rs, h, d, p, q, a, s} = {i_srst, i_valid, i_mem_pending, i_instr, i_status, i_instr_addr, i_source_operand_a};
			// One mid-run reset
			i_srst <= k == 450;
			i_mem_pending <= ($random(seed) & 1) != 0;
			// Barrier stays presented while the stall lasts
			if (!(hit(6'h36) && (d || !o_ready)))
			begin
				x = k % 4 == 0 ? 6'h36 : k % 4 == 1 ? 6'h2d : k % 4 == 2 ? 6'h2e : 6'h15;
				w = $random(seed);
				i_valid <= k < 16 || ($random(seed) & 3) != 0;
				// Early words carry a zero trap code; some carry a foreign primary opcode
				i_instr <= {w[31:17], x, (k < 16 ? 5'h00 : w[10:6]), (k % 3 == 2 ? w[5:0] : 6'h3a)};
				i_instr_addr <= $random(seed);
				i_source_operand_a <= $random(seed);
				i_status <= k < 8 ? 32'h3 : $random(seed);
			end
			@(negedge i_clk);
			ck(o_ready, !rs && !(hit(6'h36) && d));
			ck(io_ready, !rs);
			ck(o_rf_read_idx, rs ? 5'h00 : p[31:27]);
			ck(o_trap_take, hit(6'h2d));
			ck(o_ctl_we, hit(6'h2e) && !q[1]);
			ck(o_supervisor_exc, hit(6'h2e) && q[1]);
			if (hit(6'h2d))
			begin
				ck(o_program_counter, 32'h0000_0020);
				ck(o_estatus, q);
				ck(o_status_new, cleared(q));
				ck(o_exception_return_addr_reg, a + 32'h0000_0004);
			end
			if (rs)
				{ei, ew} = 37'h0_0000_0000;
			else if (hit(6'h2e) && !q[1])
				{ei, ew} = {p[10:6], s};
			ck(o_indexed_control_reg, ei);
			ck(o_ctl_wdata, ew);
		end
		$display("run done");
		conclude;
	end
endmodule // barrier_trap_ctlwrite_exec_test
